// >>> irq_status_command_regs.v
`timescale 1ns/100ps
`include "irq_status_consts.vh"
// Host-visible interrupt, status and special-command registers.
// The serial engine (SPI or UART) drives the access port on mclk_in.
module irq_status_command_regs #(
    parameter [0:0] HAS_IFACE_PIN = 1'b1 // Variant with interface pin
) (
    input wire mclk_in,
    input wire rstn_in,
    // Register access port from the serial engine
    input wire [7:0] reg_addr_in,
    input wire wr_strobe_in,
    input wire [31:0] wr_data_in,
    input wire rd_strobe_in,
    input wire [31:0] ext_rd_data_in,
    output wire [31:0] rd_data_out,
    // Events from the metering datapath, one-cycle pulses
    input wire freeze_event_in,
    input wire zero_cross_event_in,
    input wire reactive_overflow_event_in,
    input wire active_overflow_event_in,
    input wire reactive_energy_pulse_in,
    input wire active_energy_pulse_in,
    input wire data_refresh_event_in,
    // Interface select pin, asynchronous
    input wire iface_select_pin_in,
    // Device-level outputs
    output wire irq_n_out,
    output wire write_open_out,
    output wire chan_b_sel_out,
    output wire soft_reset_out,
    output wire prot_wr_strobe_out,
    output wire [7:0] prot_wr_addr_out,
    output wire [31:0] prot_wr_data_out
);

    // Stored state
    reg [`FLAG_COUNT-1:0] int_enables_reg; // Interrupt enable bits
    reg protected_write_open_reg;          // Write protection open
    reg current_channel_select_reg;        // 0 channel A, 1 channel B
    reg command_reset_flag_reg;            // Command reset seen
    reg pin_reset_flag_reg;                // Pin or power-on reset seen
    reg [31:0] last_read_echo_reg;         // Data of last read
    reg [31:0] last_write_echo_reg;        // Data of last write
    reg [31:0] rd_data_reg;                // Registered read answer
    reg irq_n_reg;                         // Interrupt output, low active
    reg soft_reset_reg;                    // Reset pulse to the device
    reg prot_wr_strobe_reg;                // Accepted protected write
    reg [7:0] prot_wr_addr_reg;            // Its address
    reg [31:0] prot_wr_data_reg;           // Its data
    reg iface_sync1_reg;                   // Synchroniser first stage
    reg iface_sync2_reg;                   // Synchroniser second stage

    // Combinational read selection
    reg [31:0] rd_mux;

    // Flag bank wiring
    wire [`FLAG_COUNT-1:0] event_vec;
    wire [`FLAG_COUNT-1:0] flags;

    // Bundle events by flag bit position
    assign event_vec[`BIT_FREEZE] = freeze_event_in;
    assign event_vec[`BIT_ZERO_CROSS] = zero_cross_event_in;
    assign event_vec[`BIT_REACT_OVF] = reactive_overflow_event_in;
    assign event_vec[`BIT_ACT_OVF] = active_overflow_event_in;
    assign event_vec[`BIT_REACT_PULSE] = reactive_energy_pulse_in;
    assign event_vec[`BIT_ACT_PULSE] = active_energy_pulse_in;
    assign event_vec[`BIT_DATA_REFRESH] = data_refresh_event_in;

    // Command decode; only low byte of the data matters
    wire wr_cmd;
    wire [7:0] cmd_code;
    wire cmd_open;
    wire cmd_close;
    wire cmd_chan_a;
    wire cmd_chan_b;
    wire cmd_reset;

    assign wr_cmd = wr_strobe_in && (reg_addr_in == `ADDR_SPECIAL_CMD);
    assign cmd_code = wr_data_in[7:0];
    // Open and close work whatever the current state
    assign cmd_open = wr_cmd && (cmd_code == `CMD_WRITE_OPEN);
    assign cmd_close = wr_cmd && (cmd_code == `CMD_WRITE_CLOSE);
    // The remaining commands need protection open
    assign cmd_chan_a = wr_cmd && protected_write_open_reg &&
                        (cmd_code == `CMD_CHANNEL_A);
    assign cmd_chan_b = wr_cmd && protected_write_open_reg &&
                        (cmd_code == `CMD_CHANNEL_B);
    assign cmd_reset = wr_cmd && protected_write_open_reg &&
                       (cmd_code == `CMD_RESET);
    // Any other code matches none of the terms and so does nothing

    // Address decode of protected registers
    wire prot_addr;
    wire prot_wr_ok;
    wire ie_wr;

    assign prot_addr = (reg_addr_in <= `ADDR_CALIB_LAST) ||
                       (reg_addr_in == `ADDR_FAST_PULSE_A) ||
                       (reg_addr_in == `ADDR_FAST_PULSE_B) ||
                       (reg_addr_in == `ADDR_INT_ENABLES);
    // Writes to protected addresses pass only while open
    assign prot_wr_ok = wr_strobe_in && prot_addr &&
                        protected_write_open_reg;
    assign ie_wr = prot_wr_ok && (reg_addr_in == `ADDR_INT_ENABLES);

    // Reads that clear flags as a side effect
    wire rd_flags;
    wire rd_status;

    // Either flag view clears the whole bank
    assign rd_flags = rd_strobe_in &&
                      ((reg_addr_in == `ADDR_INT_FLAGS) ||
                       (reg_addr_in == `ADDR_INT_FLAGS_ALT));
    assign rd_status = rd_strobe_in && (reg_addr_in == `ADDR_SYS_STATUS);

    // Interface bit; the variant without the pin reads zero
    wire iface_bit;
    assign iface_bit = HAS_IFACE_PIN ? iface_sync2_reg : 1'b0;

    // Sticky flag storage
    event_flag_bank #(
        .WIDTH(`FLAG_COUNT)
    ) u_flags (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .event_in(event_vec),
        .clear_in(rd_flags),
        .flush_in(cmd_reset),
        .flags_out(flags)
    );

    // Read multiplexer; unknown addresses come from the other banks
    always @* begin
        rd_mux = ext_rd_data_in;
        case (reg_addr_in)
            `ADDR_INT_ENABLES: begin
                // Bit 7 is reserved and reads zero
                rd_mux = {25'h0000000, int_enables_reg};
            end
            `ADDR_INT_FLAGS: begin
                rd_mux = {25'h0000000, flags};
            end
            `ADDR_INT_FLAGS_ALT: begin
                // Freeze bit is not shown in this view
                rd_mux = {26'h0000000, flags[`ALT_VIEW_BITS-1:0]};
            end
            `ADDR_SYS_STATUS: begin
                rd_mux = 32'h00000000;
                rd_mux[`STAT_WRITE_OPEN] = protected_write_open_reg;
                rd_mux[`STAT_IFACE_SEL] = iface_bit;
                rd_mux[`STAT_CMD_RESET] = command_reset_flag_reg;
                rd_mux[`STAT_PIN_RESET] = pin_reset_flag_reg;
            end
            `ADDR_READ_ECHO: begin
                rd_mux = last_read_echo_reg;
            end
            `ADDR_WRITE_ECHO: begin
                rd_mux = last_write_echo_reg;
            end
            `ADDR_SPECIAL_CMD: begin
                // Write-only; reads give zero
                rd_mux = 32'h00000000;
            end
            default: begin
                rd_mux = ext_rd_data_in;
            end
        endcase
    end

    // Two-stage synchroniser for the interface select pin
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            iface_sync1_reg <= 1'b0;
            iface_sync2_reg <= 1'b0;
        end else begin
            iface_sync1_reg <= iface_select_pin_in;
            iface_sync2_reg <= iface_sync1_reg;
        end
    end

    // Write protection state
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            protected_write_open_reg <= 1'b0;
        end else if (cmd_reset) begin
            // A command reset closes protection like the pin does
            protected_write_open_reg <= 1'b0;
        end else if (cmd_open) begin
            protected_write_open_reg <= 1'b1;
        end else if (cmd_close) begin
            protected_write_open_reg <= 1'b0;
        end
    end

    // Interrupt enables and channel selection
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            int_enables_reg <= `RST_INT_ENABLES;
            current_channel_select_reg <= 1'b0;
        end else if (cmd_reset) begin
            int_enables_reg <= `RST_INT_ENABLES;
            current_channel_select_reg <= 1'b0;
        end else begin
            if (ie_wr) begin
                int_enables_reg <= wr_data_in[`FLAG_COUNT-1:0];
            end
            if (cmd_chan_a) begin
                current_channel_select_reg <= 1'b0;
            end else if (cmd_chan_b) begin
                current_channel_select_reg <= 1'b1;
            end
        end
    end

    // Reset cause flags; setting wins over the clearing read
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            // Pin reset flag stands at one once the reset ends
            pin_reset_flag_reg <= 1'b1;
            command_reset_flag_reg <= 1'b0;
        end else begin
            if (rd_status) begin
                pin_reset_flag_reg <= 1'b0;
            end
            if (cmd_reset) begin
                command_reset_flag_reg <= 1'b1;
            end else if (rd_status) begin
                command_reset_flag_reg <= 1'b0;
            end
        end
    end

    // Echo registers for host transfer checks
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            last_read_echo_reg <= `RST_ECHO;
            last_write_echo_reg <= `RST_ECHO;
        end else if (cmd_reset) begin
            last_read_echo_reg <= `RST_ECHO;
            last_write_echo_reg <= `RST_ECHO;
        end else begin
            // Reading the echo itself returns and keeps the old copy
            if (rd_strobe_in) begin
                last_read_echo_reg <= rd_mux;
            end
            // Every write is kept, blocked ones too, except the command reset write, which loads the reset value
            if (wr_strobe_in) begin
                last_write_echo_reg <= wr_data_in;
            end
        end
    end

    // Registered read answer, one cycle after the strobe
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data_reg <= 32'h00000000;
        end else if (rd_strobe_in) begin
            rd_data_reg <= rd_mux;
        end
    end

    // Interrupt output follows the enabled flags; the enables never
    // touch the flags themselves
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_n_reg <= 1'b1;
        end else begin
            irq_n_reg <= ~(|(flags & int_enables_reg));
        end
    end

    // Reset pulse for the rest of the device, one cycle long
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            soft_reset_reg <= 1'b0;
        end else begin
            soft_reset_reg <= cmd_reset;
        end
    end

    // Accepted writes to calibration, fast-pulse and enable registers,
    // handed on so the other banks need no protection logic of their own
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prot_wr_strobe_reg <= 1'b0;
            prot_wr_addr_reg <= 8'h00;
            prot_wr_data_reg <= 32'h00000000;
        end else begin
            prot_wr_strobe_reg <= prot_wr_ok;
            if (prot_wr_ok) begin
                prot_wr_addr_reg <= reg_addr_in;
                prot_wr_data_reg <= wr_data_in;
            end
        end
    end

    // Outputs straight from flip-flops
    assign rd_data_out = rd_data_reg;
    assign irq_n_out = irq_n_reg;
    assign write_open_out = protected_write_open_reg;
    assign chan_b_sel_out = current_channel_select_reg;
    assign soft_reset_out = soft_reset_reg;
    assign prot_wr_strobe_out = prot_wr_strobe_reg;
    assign prot_wr_addr_out = prot_wr_addr_reg;
    assign prot_wr_data_out = prot_wr_data_reg;

endmodule // irq_status_command_regs

// >>> irq_status_consts.vh
`ifndef IRQ_STATUS_CONSTS_VH
`define IRQ_STATUS_CONSTS_VH

// Register addresses
`define ADDR_CALIB_LAST 8'h17
`define ADDR_FAST_PULSE_A 8'h20
`define ADDR_FAST_PULSE_B 8'h21
`define ADDR_INT_ENABLES 8'h40
`define ADDR_INT_FLAGS 8'h41
`define ADDR_INT_FLAGS_ALT 8'h42
`define ADDR_SYS_STATUS 8'h43
`define ADDR_READ_ECHO 8'h44
`define ADDR_WRITE_ECHO 8'h45
`define ADDR_SPECIAL_CMD 8'hEA

// Command data codes
`define CMD_WRITE_OPEN 8'hE5
`define CMD_WRITE_CLOSE 8'hDC
`define CMD_CHANNEL_A 8'h5A
`define CMD_CHANNEL_B 8'hA5
`define CMD_RESET 8'hFA

// Flag and enable bit positions
`define FLAG_COUNT 7
`define BIT_FREEZE 6
`define BIT_ZERO_CROSS 5
`define BIT_REACT_OVF 4
`define BIT_ACT_OVF 3
`define BIT_REACT_PULSE 2
`define BIT_ACT_PULSE 1
`define BIT_DATA_REFRESH 0
`define ALT_VIEW_BITS 6

// System status bit positions
`define STAT_WRITE_OPEN 4
`define STAT_IFACE_SEL 2
`define STAT_CMD_RESET 1
`define STAT_PIN_RESET 0

// Reset values
`define RST_INT_ENABLES 7'h00
`define RST_ECHO 32'h00000000

`endif

// >>> event_flag_bank.v
`timescale 1ns/100ps
// Sticky event flags, one flip-flop per event
module event_flag_bank #(
    parameter WIDTH = 7
) (
    input wire mclk_in,
    input wire rstn_in,
    input wire [WIDTH-1:0] event_in,  // One-cycle event strobes
    input wire clear_in,              // Host read clears every flag
    input wire flush_in,              // Command reset empties the bank
    output wire [WIDTH-1:0] flags_out // Current flag state
);

    reg [WIDTH-1:0] flag_reg; // Sticky flags

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            // Set wins over the read clear so no event is lost
            always @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    flag_reg[i] <= 1'b0;
                end else if (flush_in) begin
                    flag_reg[i] <= 1'b0;
                end else if (event_in[i]) begin
                    flag_reg[i] <= 1'b1;
                end else if (clear_in) begin
                    flag_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign flags_out = flag_reg;

endmodule // event_flag_bank

// >>> irq_status_command_regs_properties.sv
`timescale 1ns/100ps
// Watches the register port, the command outputs and the read answers
module irq_status_command_regs_properties (
    input wire mclk_in,
    input wire rstn_in,
    input wire [7:0] reg_addr_in,
    input wire wr_strobe_in,
    input wire [31:0] wr_data_in,
    input wire rd_strobe_in,
    input wire [31:0] rd_data_out,
    input wire freeze_event_in,
    input wire write_open_out,
    input wire chan_b_sel_out,
    input wire soft_reset_out,
    input wire prot_wr_strobe_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);
    // Decoded requests
    wire cmd_w = wr_strobe_in && reg_addr_in == 8'hEA;
    wire [7:0] cd = wr_data_in[7:0];
    wire rd41 = rd_strobe_in && reg_addr_in == 8'h41;
    wire rd_fl = rd41 || (rd_strobe_in && reg_addr_in == 8'h42);
    wire cmd_rst = cmd_w && cd == 8'hFA && write_open_out;
    reg fz_seen; // Freeze event not yet read back
    // Shadow of the freeze flag; command reset wins over a new event
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fz_seen <= 1'b0;
        end else if (cmd_rst) begin
            fz_seen <= 1'b0;
        end else if (freeze_event_in) begin
            fz_seen <= 1'b1;
        end else if (rd_fl) begin
            fz_seen <= 1'b0;
        end
    end
    // Status read with no write beside it
    sequence s_st;
        rd_strobe_in && !wr_strobe_in && reg_addr_in == 8'h43;
    endsequence
    // Two status reads with no write between them
    sequence s_st_twice;
        s_st ##1 (!wr_strobe_in)[*2] ##1 s_st;
    endsequence
    AST_FLAG_SET: assert property (
        rd41 && !freeze_event_in |=> rd_data_out[6] == $past(fz_seen))
        else $error("freeze flag wrong");
    AST_RSVD_IF: assert property (
        rd41 |=> rd_data_out[31:7] == 25'h0)
        else $error("flag register upper bits set");
    AST_RSVD_ALT: assert property (
        rd_strobe_in && reg_addr_in == 8'h42 |=> rd_data_out[31:6] == 26'h0)
        else $error("alternate view upper bits set");
    AST_STAT_CLR: assert property (
        s_st_twice |=> rd_data_out[1:0] == 2'b00)
        else $error("reset flags survived a read");
    AST_OPEN: assert property (
        cmd_w && cd == 8'hE5 |=> write_open_out)
        else $error("open command ignored");
    AST_CLOSE: assert property (
        cmd_w && cd == 8'hDC |=> !write_open_out)
        else $error("close command ignored");
    AST_PROT_SHUT: assert property (
        wr_strobe_in && !write_open_out && (reg_addr_in <= 8'h17 || reg_addr_in == 8'h20 ||
        reg_addr_in == 8'h21 || reg_addr_in == 8'h40) |=> !prot_wr_strobe_out)
        else $error("protected write passed while closed");
    AST_CHAN: assert property (
        cmd_w && write_open_out && (cd == 8'hA5 || cd == 8'h5A)
        |=> chan_b_sel_out == $past(wr_data_in[7]))
        else $error("channel select wrong");
    AST_CHAN_HOLD: assert property (
        cmd_w && !write_open_out && (cd == 8'hA5 || cd == 8'h5A) |=> $stable(chan_b_sel_out))
        else $error("channel changed while closed");
    AST_SOFT_RST: assert property (
        cmd_rst |=> soft_reset_out && !write_open_out)
        else $error("command reset not carried out");
    AST_ODD_CMD: assert property (
        cmd_w && !(cd inside {8'hE5, 8'hDC, 8'h5A, 8'hA5, 8'hFA})
        |=> $stable(write_open_out) && $stable(chan_b_sel_out) && !soft_reset_out)
        else $error("unknown command changed state");
endmodule // irq_status_command_regs_properties

bind irq_status_command_regs irq_status_command_regs_properties u_props (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .wr_strobe_in(wr_strobe_in), .wr_data_in(wr_data_in), .rd_strobe_in(rd_strobe_in),
    .rd_data_out(rd_data_out), .freeze_event_in(freeze_event_in),
    .write_open_out(write_open_out), .chan_b_sel_out(chan_b_sel_out),
    .soft_reset_out(soft_reset_out), .prot_wr_strobe_out(prot_wr_strobe_out));

// >>> host_model.sv
`timescale 1ns/100ps
// Host side of the register port; one request per call, driven on the falling edge
module host_model (
    input wire mclk_in,
    input wire [31:0] rd_data_out,
    output reg [7:0] reg_addr_in,
    output reg wr_strobe_in,
    output reg [31:0] wr_data_in,
    output reg rd_strobe_in
);
    // Idle bus at time zero
    initial begin
        reg_addr_in = 8'h00;
        wr_strobe_in = 1'b0;
        wr_data_in = 32'h0;
        rd_strobe_in = 1'b0;
    end
    // Write; released lines show the inverse so stale values never look valid
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(negedge mclk_in);
            reg_addr_in = a;
            wr_data_in = d;
            wr_strobe_in = 1'b1;
            @(negedge mclk_in);
            wr_strobe_in = 1'b0;
            reg_addr_in = ~a;
            wr_data_in = ~d;
        end
    endtask
    // Read; the answer stands from the cycle after the taking edge
    task rd(input [7:0] a, output [31:0] d);
        begin
            @(negedge mclk_in);
            reg_addr_in = a;
            rd_strobe_in = 1'b1;
            @(negedge mclk_in);
            rd_strobe_in = 1'b0;
            reg_addr_in = ~a;
            d = rd_data_out;
        end
    endtask
endmodule // host_model

// >>> irq_status_command_regs_tb_top.sv
`timescale 1ns/100ps
module irq_status_command_regs_tb_top;
    reg mclk_in = 1'b0;
    reg rstn_in = 1'b0;
    reg [31:0] ext_rd_data_in = 32'h0;
    reg [6:0] evt = 7'h00; // Event strobes, flag bit order
    reg iface_select_pin_in = 1'b1;
    wire [7:0] reg_addr_in;
    wire wr_strobe_in;
    wire rd_strobe_in;
    wire [31:0] wr_data_in;
    wire [31:0] rd_data_out;
    wire irq_n_out;
    wire write_open_out;
    wire chan_b_sel_out;
    wire soft_reset_out;
    wire prot_wr_strobe_out;
    wire [7:0] prot_wr_addr_out;
    wire [31:0] prot_wr_data_out;
    integer err_total = 0;
    integer n_checks = 0;
    integer i;
    reg [15:0] lfsr = 16'hDC90; // Seed 56464
    // Reference state of the block
    reg [6:0] m_flags = 7'h00;
    reg [6:0] m_en = 7'h00;
    reg m_open = 1'b0;
    reg m_chan = 1'b0;
    reg m_cmd = 1'b0;
    reg m_pin = 1'b1; // Pin reset flag is up after power-on
    reg [31:0] m_rde = 32'h0;
    reg [31:0] m_wre = 32'h0;

    always #5 mclk_in = ~mclk_in;

    irq_status_command_regs DUT (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
        .wr_strobe_in(wr_strobe_in), .wr_data_in(wr_data_in), .rd_strobe_in(rd_strobe_in),
        .ext_rd_data_in(ext_rd_data_in), .rd_data_out(rd_data_out),
        .freeze_event_in(evt[6]), .zero_cross_event_in(evt[5]),
        .reactive_overflow_event_in(evt[4]), .active_overflow_event_in(evt[3]),
        .reactive_energy_pulse_in(evt[2]), .active_energy_pulse_in(evt[1]),
        .data_refresh_event_in(evt[0]), .iface_select_pin_in(iface_select_pin_in),
        .irq_n_out(irq_n_out), .write_open_out(write_open_out),
        .chan_b_sel_out(chan_b_sel_out), .soft_reset_out(soft_reset_out),
        .prot_wr_strobe_out(prot_wr_strobe_out), .prot_wr_addr_out(prot_wr_addr_out),
        .prot_wr_data_out(prot_wr_data_out));

    host_model host (
        .mclk_in(mclk_in), .rd_data_out(rd_data_out), .reg_addr_in(reg_addr_in),
        .wr_strobe_in(wr_strobe_in), .wr_data_in(wr_data_in), .rd_strobe_in(rd_strobe_in));

    // Random source
    function [15:0] nxt(input [15:0] s);
        nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Compare and count
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // Write, then check what the write produced one cycle later
    task wrt(input [7:0] a, input [31:0] d);
        reg acc;
        reg rst;
        begin
            acc = m_open && (a <= 8'h17 || a == 8'h20 || a == 8'h21 || a == 8'h40);
            rst = m_open && a == 8'hEA && d[7:0] == 8'hFA;
            host.wr(a, d);
            m_wre = d;
            if (acc && a == 8'h40) begin
                m_en = d[6:0];
            end
            if (a == 8'hEA) begin
                case (d[7:0])
                    8'hE5: m_open = 1'b1;
                    8'hDC: m_open = 1'b0;
                    8'h5A: m_chan = m_open ? 1'b0 : m_chan;
                    8'hA5: m_chan = m_open ? 1'b1 : m_chan;
                    default: m_chan = m_chan;
                endcase
            end
            // Command reset returns all but the pin and command flags to reset values; it sets the command flag
            if (rst) begin
                m_flags = 7'h00;
                m_en = 7'h00;
                m_rde = 32'h0;
                m_wre = 32'h0;
                m_chan = 1'b0;
                m_open = 1'b0;
                m_cmd = 1'b1;
            end
            chk(prot_wr_strobe_out, acc);
            if (acc) begin
                chk(prot_wr_addr_out, a);
                chk(prot_wr_data_out, d);
            end
            chk(write_open_out, m_open);
            chk(chan_b_sel_out, m_chan);
            chk(soft_reset_out, rst);
        end
    endtask

    // Read, compare with the reference, apply side effects, then check the interrupt
    task rdc(input [7:0] a);
        reg [31:0] d;
        reg [31:0] e;
        begin
            lfsr = nxt(lfsr);
            ext_rd_data_in = {lfsr, ~lfsr};
            case (a)
                8'h41: e = {25'h0, m_flags};
                8'h42: e = {26'h0, m_flags[5:0]};
                8'h43: e = {27'h0, m_open, 1'b0, iface_select_pin_in, m_cmd, m_pin};
                8'h44: e = m_rde;
                8'h45: e = m_wre;
                8'hEA: e = 32'h0;
                default: e = ext_rd_data_in;
            endcase
            host.rd(a, d);
            chk(d, e);
            m_rde = e;
            if (a == 8'h41 || a == 8'h42) begin
                m_flags = 7'h00;
            end
            if (a == 8'h43) begin
                m_cmd = 1'b0;
                m_pin = 1'b0;
            end
            @(negedge mclk_in);
            chk(irq_n_out, ~|(m_flags & m_en));
        end
    endtask

    // One-cycle event strobes; the interrupt follows two edges later
    task pulse(input [6:0] b);
        begin
            @(negedge mclk_in);
            evt = b;
            @(negedge mclk_in);
            evt = 7'h00;
            m_flags = m_flags | b;
            @(negedge mclk_in);
            chk(irq_n_out, ~|(m_flags & m_en));
        end
    endtask

    // Verdict and end of run
    task end_of_test;
        begin
            if (err_total == 0 && n_checks > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge mclk_in);
        err_total = err_total + 1;
        end_of_test;
    end

    // Main sequence
    initial begin
        repeat (6) @(negedge mclk_in);
        rstn_in = 1'b1;
        // Interface bit needs two edges through its synchroniser before a status read
        repeat (2) @(negedge mclk_in);
        rdc(8'h43);
        rdc(8'h43);
        wrt(8'h40, 32'h0000007F);
        wrt(8'hEA, 32'h000000A5);
        rdc(8'h45);
        wrt(8'hEA, 32'h000000E5);
        rdc(8'h43);
        wrt(8'hEA, 32'h000000A5);
        wrt(8'hEA, 32'h00000033);
        wrt(8'hEA, 32'h0000005A);
        wrt(8'h17, 32'h12345678);
        iface_select_pin_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        rdc(8'h43);
        // Random events, enables and flag reads
        for (i = 0; i < 24; i = i + 1) begin
            lfsr = nxt(lfsr);
            if (i % 4 == 0) begin
                wrt(8'h40, {16'h0, lfsr});
            end
            pulse(lfsr[13:7]);
            rdc(i[0] ? 8'h41 : 8'h42);
        end
        rdc(8'h41);
        rdc(8'h41);
        rdc(8'h30);
        rdc(8'h44);
        rdc(8'hEA);
        // Command reset with flags pending, then protection is closed
        pulse(7'h7F);
        wrt(8'hEA, 32'h000000FA);
        rdc(8'h43);
        rdc(8'h41);
        wrt(8'h40, 32'h00000001);
        wrt(8'hEA, 32'h000000E5);
        wrt(8'hEA, 32'h000000DC);
        wrt(8'h20, 32'h00000055);
        end_of_test;
    end
endmodule // irq_status_command_regs_tb_top
